//--- uart_mdrop_pkg.sv
// shared constants and types for the multi-drop serial transceiver
package uart_mdrop_pkg;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] DATA_PORT_ADDR = 3'h0;
  localparam logic [ADDR_W-1:0] CTRL_A_ADDR = 3'h1;
  localparam logic [ADDR_W-1:0] CTRL_B_ADDR = 3'h2;
  localparam logic [ADDR_W-1:0] BAUD_LOW_ADDR = 3'h3;
  localparam logic [ADDR_W-1:0] SHARED_ADDR = 3'h4;
  // bit positions
  localparam int SEL_BIT = 7;
  localparam int TXC_BIT = 6;
  localparam int DBL_BIT = 1;
  localparam int MULTIDROP_FILTER_ENABLE_BIT = 0;
  // values after reset
  localparam logic [7:0] CTRL_A_RST = 8'h20;
  localparam logic [6:0] CTRL_C_RST = 7'h06;
  localparam logic [3:0] BAUD_HIGH_RST = 4'h0;
  localparam logic [7:0] BAUD_LOW_RST = 8'h00;
  // oversampling counts per bit
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam int RX_DEPTH = 2;

  typedef struct packed {
    logic pe;
    logic overrun_flag;
    logic fe;
    logic [8:0] data;
  } rx_word_t;

  typedef struct packed {
    logic par_en;
    logic par_odd;
    logic two_stop;
    logic [3:0] nbits;
  } frame_cfg_t;

  // character size code to number of data bits
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction
endpackage

//--- sync_fifo.sv
// synchronous fifo with valid/ready on both sides and flush
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != CW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= bump(wr_ptr_r);
      if (pop) rd_ptr_r <= bump(rd_ptr_r);
      if (push && !pop) count_r <= count_r + 1'b1;
      else if (pop && !push) count_r <= count_r - 1'b1;
    end
  end
endmodule

//--- uart_tx_shifter.sv
// transmit shift register: start, data lsb first, parity, one or two stops
`timescale 1ns/1ps
module uart_tx_shifter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ovs_tick,
  input wire logic [4:0] spb,
  input wire logic load,
  input wire logic [8:0] load_data,
  input wire uart_mdrop_pkg::frame_cfg_t cfg,
  output logic idle,
  output logic done,
  output logic txd
);
  import uart_mdrop_pkg::*;
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_START = 3'b001, T_DATA = 3'b010,
    T_PAR = 3'b011, T_STOP1 = 3'b100, T_STOP2 = 3'b101
  } tx_state_t;
  tx_state_t st_r;
  logic [8:0] sh_r;
  logic [3:0] cnt_r;
  logic [4:0] ph_r;
  logic par_r;
  logic bit_end;

  assign idle = (st_r == T_IDLE);
  assign bit_end = ovs_tick && (ph_r == spb - 5'h01);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ph_r <= '0;
    else if (st_r == T_IDLE || bit_end) ph_r <= '0;
    else if (ovs_tick) ph_r <= ph_r + 5'h01;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= T_IDLE;
      sh_r <= '0;
      cnt_r <= '0;
      par_r <= 1'b0;
      txd <= 1'b1;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_r)
        T_IDLE: begin
          txd <= 1'b1;
          if (load) begin
            sh_r <= load_data;
            par_r <= cfg.par_odd;
            cnt_r <= '0;
            txd <= 1'b0;
            st_r <= T_START;
          end
        end
        T_START: begin
          if (bit_end) begin
            txd <= sh_r[0];
            par_r <= par_r ^ sh_r[0];
            sh_r <= {1'b0, sh_r[8:1]};
            cnt_r <= 4'h1;
            st_r <= T_DATA;
          end
        end
        T_DATA: begin
          if (bit_end) begin
            if (cnt_r == cfg.nbits) begin
              txd <= cfg.par_en ? par_r : 1'b1;
              st_r <= cfg.par_en ? T_PAR : T_STOP1;
            end else begin
              txd <= sh_r[0];
              par_r <= par_r ^ sh_r[0];
              sh_r <= {1'b0, sh_r[8:1]};
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        T_PAR: begin
          if (bit_end) begin
            txd <= 1'b1;
            st_r <= T_STOP1;
          end
        end
        T_STOP1: begin
          if (bit_end) begin
            st_r <= cfg.two_stop ? T_STOP2 : T_IDLE;
            done <= !cfg.two_stop;
          end
        end
        T_STOP2: begin
          if (bit_end) begin
            st_r <= T_IDLE;
            done <= 1'b1;
          end
        end
        default: st_r <= T_IDLE;
      endcase
    end
  end
endmodule

//--- uart_multidrop.sv
// serial transceiver register side with multi-drop address filter
`timescale 1ns/1ps
// Summary of operation
// - with filter on, data-type frames are dropped, never stored or flagged.
// - transmitter ignores the filter enable entirely.
// - for 5 to 8 data bits the first stop bit is the frame type.
// - for 9 data bits the received ninth bit is the frame type.
// - frame type one means address, zero means data.
// - address frames under the filter are stored and flagged as usual.
// - shared write: bit 7 zero writes baud high, one writes control c.
// - shared read gives baud high, or control c if read last cycle.
// - data port write goes to transmit buffer, read gives receive buffer.
// - short characters: upper tx bits ignored, upper rx bits read zero.
// - data port write while transmit buffer is full is discarded.
// - enabled transmitter moves buffer to shifter when empty, shifts it out.
// - receive buffer is a two-entry fifo advanced by every data port read.
// - tx complete clears by writing one or by interrupt service.
// - transmit-buffer-empty flag is set after reset.
// - control c read back shows bit 7 as one.
// - rx complete means unread data; disabling receiver flushes buffer.
module uart_multidrop (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [uart_mdrop_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic tx_complete_ack,
  input wire logic rxd,
  output logic txd
);
  import uart_mdrop_pkg::*;
  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
    R_PAR = 3'b011, R_STOP = 3'b100
  } rx_state_t;

  logic double_speed_select_r, multidrop_filter_enable_r, tx_complete_flag_r;
  logic [2:0] int_en_r;
  logic rx_en_r, tx_en_r, char_size2_r, tx_ninth_bit_r;
  logic [6:0] ctrl_c_r;
  logic [3:0] baud_divisor_high_r;
  logic [7:0] baud_low_r;
  logic shared_rd_prev_r;
  logic [11:0] pre_cnt_r;
  logic ovs_tick_r;
  logic [8:0] tx_hold_buffer_r;
  logic tx_buf_full_r;
  logic rxd_m_r, rxd_s_r;
  rx_state_t rst_st_r;
  logic [4:0] rph_r;
  logic [3:0] rcnt_r;
  logic [8:0] rsh_r;
  logic rpar_r, rx_done_r, stop_bit_r;
  rx_word_t hold_r;
  logic hold_valid_r, ovr_pend_r;

  logic sel_data, sel_a, sel_b, sel_bl, sel_sh;
  logic [4:0] spb;
  frame_cfg_t cfg;
  logic tx_idle, tx_done, tx_load, tx_buffer_empty_flag;
  logic rx_tick_end, rx_half_end;
  logic frame_type, hold_load, fifo_in_ready, rx_complete_flag;
  rx_word_t head;
  logic [7:0] ctrl_a_rd, ctrl_b_rd;

  assign sel_data = (reg_addr == DATA_PORT_ADDR);
  assign sel_a = (reg_addr == CTRL_A_ADDR);
  assign sel_b = (reg_addr == CTRL_B_ADDR);
  assign sel_bl = (reg_addr == BAUD_LOW_ADDR);
  assign sel_sh = (reg_addr == SHARED_ADDR);
  assign spb = double_speed_select_r ? SPB_DOUBLE : SPB_NORMAL;
  // frame format shared by both directions; the filter enable is not in it
  assign cfg.par_en = ctrl_c_r[5];
  assign cfg.par_odd = ctrl_c_r[4];
  assign cfg.two_stop = ctrl_c_r[3];
  assign cfg.nbits = char_bits({char_size2_r, ctrl_c_r[2:1]});
  assign tx_buffer_empty_flag = !tx_buf_full_r;

  // control registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      double_speed_select_r <= CTRL_A_RST[DBL_BIT];
      multidrop_filter_enable_r <= CTRL_A_RST[MULTIDROP_FILTER_ENABLE_BIT];
      int_en_r <= '0;
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
      char_size2_r <= 1'b0;
      tx_ninth_bit_r <= 1'b0;
      baud_low_r <= BAUD_LOW_RST;
    end else if (reg_wr) begin
      if (sel_a) begin
        double_speed_select_r <= reg_wdata[DBL_BIT];
        multidrop_filter_enable_r <= reg_wdata[MULTIDROP_FILTER_ENABLE_BIT];
      end
      if (sel_b) begin
        int_en_r <= reg_wdata[7:5];
        rx_en_r <= reg_wdata[4];
        tx_en_r <= reg_wdata[3];
        char_size2_r <= reg_wdata[2];
        tx_ninth_bit_r <= reg_wdata[0];
      end
      if (sel_bl) baud_low_r <= reg_wdata;
    end
  end

  // shared location: write target picked by the top bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_c_r <= CTRL_C_RST;
      baud_divisor_high_r <= BAUD_HIGH_RST;
    end else if (reg_wr && sel_sh) begin
      if (reg_wdata[SEL_BIT]) ctrl_c_r <= reg_wdata[6:0];
      else baud_divisor_high_r <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) shared_rd_prev_r <= 1'b0;
    else shared_rd_prev_r <= reg_rd && sel_sh;
  end

  // oversampling prescaler
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_cnt_r <= '0;
      ovs_tick_r <= 1'b0;
    end else begin
      ovs_tick_r <= (pre_cnt_r == '0);
      if (pre_cnt_r == '0) pre_cnt_r <= {baud_divisor_high_r, baud_low_r};
      else pre_cnt_r <= pre_cnt_r - 12'h001;
    end
  end

  // transmit buffer and handoff to the shifter
  assign tx_load = tx_en_r && tx_buf_full_r && tx_idle;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_buf_full_r <= 1'b0;
      tx_hold_buffer_r <= '0;
    end else if (reg_wr && sel_data && !tx_buf_full_r) begin
      tx_buf_full_r <= 1'b1;
      tx_hold_buffer_r <= {tx_ninth_bit_r, reg_wdata};
    end else if (tx_load) begin
      tx_buf_full_r <= 1'b0;
    end
  end

  // a completion in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) tx_complete_flag_r <= CTRL_A_RST[TXC_BIT];
    else if (tx_done && !tx_buf_full_r) tx_complete_flag_r <= 1'b1;
    else if ((reg_wr && sel_a && reg_wdata[TXC_BIT]) || tx_complete_ack)
      tx_complete_flag_r <= 1'b0;
  end

  uart_tx_shifter u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .ovs_tick(ovs_tick_r),
    .spb(spb),
    .load(tx_load),
    .load_data(tx_hold_buffer_r),
    .cfg(cfg),
    .idle(tx_idle),
    .done(tx_done),
    .txd(txd)
  );

  // receive line synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd;
      rxd_s_r <= rxd_m_r;
    end
  end

  assign rx_tick_end = ovs_tick_r && (rph_r == spb - 5'h01);
  assign rx_half_end = ovs_tick_r && (rph_r == (spb >> 1) - 5'h01);

  // receiver: centre of the start bit, then one sample per bit period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rst_st_r <= R_IDLE;
      rph_r <= '0;
      rcnt_r <= '0;
      rsh_r <= '0;
      rpar_r <= 1'b0;
      stop_bit_r <= 1'b1;
      rx_done_r <= 1'b0;
    end else begin
      rx_done_r <= 1'b0;
      if (ovs_tick_r) rph_r <= rph_r + 5'h01;
      case (rst_st_r)
        R_IDLE: begin
          rph_r <= '0;
          if (rx_en_r && !rxd_s_r) rst_st_r <= R_START;
        end
        R_START: begin
          if (rx_half_end) begin
            rph_r <= '0;
            rcnt_r <= '0;
            rsh_r <= '0;
            rpar_r <= cfg.par_odd;
            rst_st_r <= rxd_s_r ? R_IDLE : R_DATA;
          end
        end
        R_DATA: begin
          if (rx_tick_end) begin
            rph_r <= '0;
            rsh_r[rcnt_r] <= rxd_s_r;
            rpar_r <= rpar_r ^ rxd_s_r;
            rcnt_r <= rcnt_r + 4'h1;
            if (rcnt_r == cfg.nbits - 4'h1)
              rst_st_r <= cfg.par_en ? R_PAR : R_STOP;
          end
        end
        R_PAR: begin
          if (rx_tick_end) begin
            rph_r <= '0;
            rpar_r <= rpar_r ^ rxd_s_r;
            rst_st_r <= R_STOP;
          end
        end
        R_STOP: begin
          if (rx_tick_end) begin
            stop_bit_r <= rxd_s_r;
            rx_done_r <= 1'b1;
            rst_st_r <= R_IDLE;
          end
        end
        default: rst_st_r <= R_IDLE;
      endcase
      if (!rx_en_r) rst_st_r <= R_IDLE;
    end
  end

  // frame type: first stop bit, or ninth data bit for 9-bit characters
  assign frame_type = (cfg.nbits == 4'h9) ? rsh_r[8] : stop_bit_r;
  assign hold_load = rx_done_r && rx_en_r
    && (!multidrop_filter_enable_r || frame_type);

  // one character may wait here while the fifo is full
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_valid_r <= 1'b0;
      hold_r <= '0;
      ovr_pend_r <= 1'b0;
    end else if (!rx_en_r) begin
      hold_valid_r <= 1'b0;
      ovr_pend_r <= 1'b0;
    end else begin
      if (hold_valid_r && !fifo_in_ready && rst_st_r == R_IDLE && !rxd_s_r)
        ovr_pend_r <= 1'b1;
      if (hold_load && (!hold_valid_r || fifo_in_ready)) begin
        hold_valid_r <= 1'b1;
        hold_r.data <= rsh_r;
        hold_r.fe <= !stop_bit_r;
        hold_r.pe <= cfg.par_en && rpar_r;
        hold_r.overrun_flag <= 1'b0;
      end else if (hold_valid_r && fifo_in_ready) begin
        hold_valid_r <= 1'b0;
      end
      if (hold_valid_r && fifo_in_ready) ovr_pend_r <= 1'b0;
    end
  end

  sync_fifo #(.WIDTH($bits(rx_word_t)), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .flush(!rx_en_r),
    .in_valid(hold_valid_r),
    .in_ready(fifo_in_ready),
    .in_data({hold_r.pe, ovr_pend_r, hold_r.fe, hold_r.data}),
    .out_valid(rx_complete_flag),
    .out_ready(reg_rd && sel_data),
    .out_data(head)
  );

  assign ctrl_a_rd = {rx_complete_flag, tx_complete_flag_r,
    tx_buffer_empty_flag, head.fe & rx_complete_flag,
    head.overrun_flag & rx_complete_flag, head.pe & rx_complete_flag,
    double_speed_select_r, multidrop_filter_enable_r};
  assign ctrl_b_rd = {int_en_r, rx_en_r, tx_en_r, char_size2_r,
    head.data[8] & rx_complete_flag, tx_ninth_bit_r};

  // registered read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (sel_data)
        reg_rdata <= rx_complete_flag ? head.data[7:0] : 8'h00;
      else if (sel_a) reg_rdata <= ctrl_a_rd;
      else if (sel_b) reg_rdata <= ctrl_b_rd;
      else if (sel_bl) reg_rdata <= baud_low_r;
      else if (sel_sh && shared_rd_prev_r)
        reg_rdata <= {1'b1, ctrl_c_r};
      else if (sel_sh) reg_rdata <= {4'h0, baud_divisor_high_r};
      else reg_rdata <= 8'h00;
    end
  end

  filter_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done_r && multidrop_filter_enable_r && !frame_type |=> $stable(hold_r))
    else $error("data frame passed the filter");
  addr_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done_r && rx_en_r && frame_type && !hold_valid_r |=> hold_valid_r)
    else $error("address frame not stored");
  nine_type_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_done_r && cfg.nbits == 4'h9 |-> frame_type == rsh_r[8])
    else $error("ninth bit not used as frame type");
  shared_wr_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_sh && !reg_wdata[7] |=>
    baud_divisor_high_r == $past(reg_wdata[3:0]) && $stable(ctrl_c_r))
    else $error("shared write hit wrong register");
  shared_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_rd && sel_sh ##1 reg_rd && sel_sh |=> reg_rdata[7])
    else $error("second shared read lacks control c");
  first_rd_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(reg_rd && sel_sh) ##1 reg_rd && sel_sh |=> reg_rdata[7:4] == 4'h0)
    else $error("first shared read not baud high");
  full_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    reg_wr && sel_data && tx_buf_full_r |=> $stable(tx_hold_buffer_r))
    else $error("write into full transmit buffer");
  tx_move_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_load && !(reg_wr && sel_data) |=> !tx_buf_full_r ##1 !tx_idle)
    else $error("buffer not moved to shifter");
  txc_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_complete_ack && !tx_done |=> !tx_complete_flag_r)
    else $error("tx complete not cleared");
  flush_a: assert property (@(posedge sys_clk) disable iff (rst)
    !rx_en_r ##1 !rx_en_r |-> !rx_complete_flag)
    else $error("receive buffer not flushed");
  addr_cov: cover property (@(posedge sys_clk) hold_load && frame_type);
  ctrlc_cov: cover property (@(posedge sys_clk) reg_rd && sel_sh
    && shared_rd_prev_r);
  full_cov: cover property (@(posedge sys_clk) !fifo_in_ready && hold_valid_r);
endmodule

//--- uart_node_model.sv
// far-side serial node: sends frames on rxd, decodes frames from txd
`timescale 1ns/1ps
module uart_node_model #(
  parameter int SPB = 16
) (
  input wire logic sys_clk,
  output logic rxd_line,
  input wire logic txd_line
);
  initial rxd_line = 1'b1;

  // start, n data bits lsb first, type bit as first stop, then a second stop
  task automatic send(input logic [8:0] v, input int n, input logic stop1);
    int i;
    @(negedge sys_clk);
    rxd_line = 1'b0;
    repeat (SPB) @(negedge sys_clk);
    for (i = 0; i < n; i++) begin
      rxd_line = v[i];
      repeat (SPB) @(negedge sys_clk);
    end
    rxd_line = stop1;
    repeat (SPB) @(negedge sys_clk);
    rxd_line = 1'b1;
    repeat (SPB) @(negedge sys_clk);
  endtask

  // waits for a start bit, samples each bit at its centre
  task automatic recv(input int n, output logic [8:0] d, output logic s);
    int i;
    d = '0;
    i = 0;
    // sample on the falling edge, well clear of the edge that moves txd
    while (txd_line !== 1'b0 && i < 2000) begin
      @(negedge sys_clk);
      i++;
    end
    repeat (SPB / 2) @(negedge sys_clk);
    for (i = 0; i < n; i++) begin
      repeat (SPB) @(negedge sys_clk);
      d[i] = txd_line;
    end
    repeat (SPB) @(negedge sys_clk);
    s = txd_line;
  endtask
endmodule

//--- uart_multidrop_bench.sv
// self-checking bench for the multi-drop serial transceiver
`timescale 1ns/1ps
module uart_multidrop_bench;
  import uart_mdrop_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic ack = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0;
  logic [7:0] reg_rdata;
  logic [7:0] q;
  logic [7:0] q2;
  logic rxd;
  logic txd;
  logic [8:0] d;
  logic [8:0] d2;
  logic s;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  int lows;

  always #2.5 sys_clk = ~sys_clk;

  uart_multidrop i_dut (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_complete_ack(ack), .rxd(rxd), .txd(txd)
  );

  uart_node_model i_node (.sys_clk(sys_clk), .rxd_line(rxd), .txd_line(txd));

  task automatic conclude();
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask

  // two shared-location reads in consecutive cycles
  task automatic rd2(output logic [7:0] v1, output logic [7:0] v2);
    @(negedge sys_clk);
    reg_addr = SHARED_ADDR;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    v1 = reg_rdata;
    @(negedge sys_clk);
    v2 = reg_rdata;
    reg_rd = 1'b0;
  endtask

  task automatic t_reset();
    rd(CTRL_A_ADDR, q);
    check(q, 9'h020);
    rd2(q, q2);
    check(q, 9'h000);
    check(q2, 9'h086);
    rd(3'h7, q);
    check(q, 9'h000);
  endtask

  task automatic t_shared();
    wr(SHARED_ADDR, 8'h8e);
    wr(SHARED_ADDR, 8'h03);
    rd(SHARED_ADDR, q);
    check(q, 9'h003);
    rd2(q, q2);
    check(q, 9'h003);
    check(q2, 9'h08e);
    wr(SHARED_ADDR, 8'h00);
    wr(SHARED_ADDR, 8'h86);
    // the prescaler still runs out the long count loaded meanwhile
    repeat (800) @(negedge sys_clk);
  endtask

  task automatic t_filter9();
    wr(CTRL_B_ADDR, 8'h1c);
    wr(CTRL_A_ADDR, 8'h01);
    i_node.send(9'h033, 9, 1'b1);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b0);
    i_node.send(9'h15a, 9, 1'b1);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b1);
    rd(CTRL_B_ADDR, q);
    check(q[1], 1'b1);
    rd(DATA_PORT_ADDR, q);
    check(q, 9'h05a);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b0);
    wr(CTRL_A_ADDR, 8'h00);
    i_node.send(9'h0c6, 9, 1'b1);
    rd(DATA_PORT_ADDR, q);
    check(q, 9'h0c6);
    wr(CTRL_A_ADDR, 8'h01);
  endtask

  task automatic t_filter8();
    wr(CTRL_B_ADDR, 8'h18);
    i_node.send(9'h0c3, 8, 1'b0);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b0);
    i_node.send(9'h03c, 8, 1'b1);
    rd(DATA_PORT_ADDR, q);
    check(q, 9'h03c);
  endtask

  task automatic t_tx();
    wr(CTRL_B_ADDR, 8'h1d);
    fork
      begin
        i_node.recv(9, d, s);
        i_node.recv(9, d2, s);
      end
      begin
        wr(DATA_PORT_ADDR, 8'ha5);
        wr(DATA_PORT_ADDR, 8'h5a);
        wr(DATA_PORT_ADDR, 8'hff);
        rd(CTRL_A_ADDR, q);
        check(q[5], 1'b0);
      end
    join
    check(d, 9'h1a5);
    check(d2, 9'h15a);
    lows = 0;
    repeat (400) begin
      @(posedge sys_clk);
      if (txd !== 1'b1) lows++;
    end
    check(9'(lows), 9'h000);
    rd(CTRL_A_ADDR, q);
    check(q[6:5], 2'h3);
    wr(CTRL_A_ADDR, 8'h41);
    rd(CTRL_A_ADDR, q);
    check(q[6], 1'b0);
    fork
      i_node.recv(9, d, s);
      wr(DATA_PORT_ADDR, 8'h11);
    join
    repeat (20) @(posedge sys_clk);
    rd(CTRL_A_ADDR, q);
    check(q[6], 1'b1);
    @(negedge sys_clk);
    ack = 1'b1;
    @(negedge sys_clk);
    ack = 1'b0;
    rd(CTRL_A_ADDR, q);
    check(q[6], 1'b0);
  endtask

  task automatic t_short();
    wr(CTRL_B_ADDR, 8'h18);
    wr(SHARED_ADDR, 8'h80);
    wr(CTRL_A_ADDR, 8'h00);
    fork
      i_node.recv(5, d, s);
      wr(DATA_PORT_ADDR, 8'hd5);
    join
    check(d, 9'h015);
    check(s, 1'b1);
    i_node.send(9'h1ff, 5, 1'b1);
    i_node.send(9'h00a, 5, 1'b1);
    rd(DATA_PORT_ADDR, q);
    check(q, 9'h01f);
    rd(DATA_PORT_ADDR, q);
    check(q, 9'h00a);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b0);
    i_node.send(9'h007, 5, 1'b1);
    wr(CTRL_B_ADDR, 8'h08);
    rd(CTRL_A_ADDR, q);
    check(q[7], 1'b0);
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_shared();
    t_filter9();
    t_filter8();
    t_tx();
    t_short();
    conclude();
  end
endmodule
